// [inc/calib_pkg.sv]
// package of offsets, fields, reset values and decode for the calibration register block
//
// Functional notes
// RL1 - The calibration vector port moves data only while bit 0 of the access gate is set.
// RL2 - Each read of the vector port returns the next byte of the stored calibration vector.
// RL3 - Software saves the vector by reading the port exactly 673 times in a row.
// RL4 - Software restores by writing 673 saved bytes in order; each lands in the next position.
// RL5 - With the address freeze bit set, a running transfer keeps targeting the vector port.
// RL6 - Software touches the vector port only while the calibration halted flag reads 1.
// RL7 - A transfer of fewer than 673 accesses leaves the vector invalid until one completes.
// RL8 - Each analog input has its own 8-bit gain trim; full-scale range is controlled elsewhere.
// RL9 - Trims take their fuse values after reset and stay readable and writable.
// RL10 - The reference trim holds 4 bits in 3:0; bits 7:4 are reserved and kept at zero.
// RL11 - The first input has an 8-bit termination trim using the whole register.
// RL12 - Setting the access gate anew returns the vector index to the first position.
package calib_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ACCESS_GATE = 8'h70;
  localparam logic [7:0] IDX_VECTOR_PORT = 8'h71;
  localparam logic [7:0] IDX_GAIN_FIRST = 8'h7A;
  localparam logic [7:0] IDX_GAIN_SECOND = 8'h7B;
  localparam logic [7:0] IDX_REFERENCE = 8'h7C;
  localparam logic [7:0] IDX_TERM_FIRST = 8'h7E;
  localparam logic [7:0] IDX_STREAM_CTRL = 8'h80;
  localparam logic [7:0] IDX_STATUS = 8'h81;

  localparam int unsigned ADDR_W = 12;
  localparam logic [1:0] ADDR_PAD = 2'h0;

  // vector geometry
  localparam int unsigned VEC_IDX_W = 10;
  localparam logic [9:0] VECTOR_LEN = 10'h2A1;
  localparam logic [9:0] VECTOR_LAST = VECTOR_LEN - 10'h001;
  localparam logic [9:0] VECTOR_FIRST = 10'h000;

  // field positions and widths
  localparam int unsigned GATE_BIT = 0;
  localparam int unsigned FREEZE_BIT = 0;
  localparam int unsigned REF_W = 4;
  localparam int unsigned ST_HALTED = 0;
  localparam int unsigned ST_VALID = 1;
  localparam int unsigned ST_BUSY = 2;
  localparam int unsigned ST_HAZARD = 3;

  // values after reset
  localparam logic GATE_RESET = 1'h0;
  localparam logic FREEZE_RESET = 1'h0;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_GATE, SEL_VECTOR, SEL_GAIN_A, SEL_GAIN_B,
    SEL_REF, SEL_TERM_A, SEL_CTRL, SEL_STATUS
  } sel_t;

  // byte address to register select
  function automatic sel_t decode(input logic [ADDR_W-1:0] addr);
    sel_t s;
    s = SEL_NONE;
    if (addr[1:0] == ADDR_PAD && addr[ADDR_W-1:2] >= IDX_ACCESS_GATE) begin
      case (addr[9:2])
        IDX_ACCESS_GATE: s = SEL_GATE;
        IDX_VECTOR_PORT: s = SEL_VECTOR;
        IDX_GAIN_FIRST: s = SEL_GAIN_A;
        IDX_GAIN_SECOND: s = SEL_GAIN_B;
        IDX_REFERENCE: s = SEL_REF;
        IDX_TERM_FIRST: s = SEL_TERM_A;
        IDX_STREAM_CTRL: s = SEL_CTRL;
        IDX_STATUS: s = SEL_STATUS;
        default: s = SEL_NONE;
      endcase
      if (addr[ADDR_W-1:10] != 2'h0) begin
        s = SEL_NONE;
      end
    end
    return s;
  endfunction : decode

endpackage : calib_pkg

// [inc/calib_mem_if.sv]
// carrier between the register block and the vector memory
`timescale 1ns/1ns
interface calib_mem_if;
  logic rd_en;
  logic wr_en;
  logic [calib_pkg::VEC_IDX_W-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface : calib_mem_if

// [design/calib_vector_mem.sv]
// byte memory that holds the calibration vector, registered read
`timescale 1ns/1ns
module calib_vector_mem (
  input wire logic aclk,
  input wire logic aresetn,
  calib_mem_if.mem port
);

  logic [7:0] store [0:calib_pkg::VECTOR_LEN-1];

  // write one byte at the current position
  always_ff @(posedge aclk) begin
    if (port.wr_en) begin
      store[port.addr] <= port.wdata;
    end
  end

  // read data out of a register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port.rdata <= calib_pkg::PORT_RESET;
    end else if (port.rd_en) begin
      port.rdata <= store[port.addr];
    end
  end

endmodule : calib_vector_mem

// [design/calib_trim_regs.sv]
// calibration vector port and trim registers behind an axi4-lite slave
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module calib_trim_regs (
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [calib_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [calib_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // calibration engine and fuse storage
  input wire logic calibration_halted_flag,
  input wire logic [7:0] fuse_gain_first,
  input wire logic [7:0] fuse_gain_second,
  input wire logic [calib_pkg::REF_W-1:0] fuse_reference,
  input wire logic [7:0] fuse_termination_first,
  // trims, gate state and vector valid toward the analog side
  output logic [7:0] gain_adjust_first,
  output logic [7:0] gain_adjust_second,
  output logic [calib_pkg::REF_W-1:0] reference_adjust_field,
  output logic [7:0] termination_adjust_first,
  output logic calib_access_enable,
  output logic calib_vector_valid
);

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} rd_state_t;

  calib_mem_if mem_bus ();

  // write side holding registers
  logic aw_held;
  logic w_held;
  logic [calib_pkg::ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;

  // read side
  rd_state_t rd_state;
  calib_pkg::sel_t rd_sel_q;
  logic rd_vec_q;
  logic [7:0] rd_byte;
  logic rd_err_q;

  // control and status state
  logic gate;
  logic freeze;
  logic fuse_loaded;
  logic [calib_pkg::VEC_IDX_W-1:0] vec_index;
  logic in_progress;
  logic hazard;

  // decoded strobes
  logic commit;
  logic ar_take;
  calib_pkg::sel_t wr_sel;
  calib_pkg::sel_t ar_sel;
  logic vec_wr;
  logic vec_rd;
  logic vec_step;
  logic gate_rise;

  // mid-transfer with freeze set, every access is steered to the port
  function automatic calib_pkg::sel_t steer(
    input calib_pkg::sel_t s,
    input logic frz,
    input logic busy
  );
    calib_pkg::sel_t t;
    t = s;
    if (frz && busy) begin
      t = calib_pkg::SEL_VECTOR; // RL5
    end
    return t;
  endfunction : steer

  // true when the select names the wanted register; write callers add the lane 0 check
  function automatic logic hit(input calib_pkg::sel_t s, input calib_pkg::sel_t want);
    return s == want;
  endfunction : hit

  // channel handshakes
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign commit = aw_held && w_held && !bvalid;
  assign arready = (rd_state == RD_IDLE) && !commit;
  assign ar_take = arvalid && arready;
  assign rvalid = (rd_state == RD_RESP);

  // register selection for both directions
  assign wr_sel = steer(calib_pkg::decode(aw_addr_q), freeze, in_progress);
  assign ar_sel = steer(calib_pkg::decode(araddr), freeze, in_progress);

  // vector port moves data only with the gate open
  assign vec_wr = commit && w_lane_q && hit(wr_sel, calib_pkg::SEL_VECTOR) && gate; // RL1
  assign vec_rd = ar_take && hit(ar_sel, calib_pkg::SEL_VECTOR) && gate; // RL1
  assign vec_step = vec_wr || vec_rd;
  assign gate_rise = commit && w_lane_q && hit(wr_sel, calib_pkg::SEL_GATE)
                     && w_byte_q[calib_pkg::GATE_BIT] && !gate;

  // memory port follows the shared index
  assign mem_bus.rd_en = vec_rd; // RL2
  assign mem_bus.wr_en = vec_wr; // RL4
  assign mem_bus.addr = vec_index;
  assign mem_bus.wdata = w_byte_q;

  calib_vector_mem u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(mem_bus.mem)
  );

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (commit) begin
      aw_held <= 1'b0;
    end
  end

  // write data capture, only the low byte lane carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_byte_q <= wdata[7:0];
      w_lane_q <= wstrb[0];
    end else if (commit) begin
      w_held <= 1'b0;
    end
  end

  // write response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= calib_pkg::RESP_OKAY;
    end else if (commit) begin
      bvalid <= 1'b1;
      bresp <= (wr_sel == calib_pkg::SEL_NONE) ? calib_pkg::RESP_SLVERR : calib_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // access gate and freeze control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate <= calib_pkg::GATE_RESET;
      freeze <= calib_pkg::FREEZE_RESET;
    end else if (commit && w_lane_q) begin
      if (hit(wr_sel, calib_pkg::SEL_GATE)) begin
        gate <= w_byte_q[calib_pkg::GATE_BIT]; // RL1
      end
      if (hit(wr_sel, calib_pkg::SEL_CTRL)) begin
        freeze <= w_byte_q[calib_pkg::FREEZE_BIT]; // RL5
      end
    end
  end

  // trims: fuse values on the first cycle after reset, then software owned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_loaded <= 1'b0;
      gain_adjust_first <= calib_pkg::TRIM_RESET;
      gain_adjust_second <= calib_pkg::TRIM_RESET;
      reference_adjust_field <= calib_pkg::TRIM_RESET[calib_pkg::REF_W-1:0];
      termination_adjust_first <= calib_pkg::TRIM_RESET;
    end else if (!fuse_loaded) begin
      fuse_loaded <= 1'b1;
      gain_adjust_first <= fuse_gain_first; // RL9
      gain_adjust_second <= fuse_gain_second; // RL9
      reference_adjust_field <= fuse_reference; // RL9
      termination_adjust_first <= fuse_termination_first; // RL9
    end else if (commit && w_lane_q) begin
      case (wr_sel)
        calib_pkg::SEL_GAIN_A: gain_adjust_first <= w_byte_q; // RL8
        calib_pkg::SEL_GAIN_B: gain_adjust_second <= w_byte_q; // RL8
        calib_pkg::SEL_REF: reference_adjust_field <= w_byte_q[calib_pkg::REF_W-1:0]; // RL10
        calib_pkg::SEL_TERM_A: termination_adjust_first <= w_byte_q; // RL11
        default: begin
        end
      endcase
    end
  end

  // vector index walks the whole vector, wraps after the last byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_index <= calib_pkg::VECTOR_FIRST;
      in_progress <= 1'b0;
    end else if (gate_rise) begin
      vec_index <= calib_pkg::VECTOR_FIRST; // RL12
      in_progress <= 1'b0;
    end else if (vec_step) begin
      if (vec_index == calib_pkg::VECTOR_LAST) begin
        vec_index <= calib_pkg::VECTOR_FIRST; // RL3
        in_progress <= 1'b0;
      end else begin
        vec_index <= vec_index + 10'h001; // RL2
        in_progress <= 1'b1;
      end
    end
  end

  // vector valid only after a full pass, dropped when a pass starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      calib_vector_valid <= 1'b0;
    end else if (vec_step) begin
      calib_vector_valid <= (vec_index == calib_pkg::VECTOR_LAST); // RL7
    end else if (gate_rise && in_progress) begin
      calib_vector_valid <= 1'b0; // RL7
    end
  end

  // sticky note of a port access while calibration ran; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hazard <= 1'b0;
    end else begin
      hazard <= (hazard && !gate_rise) || (vec_step && !calibration_halted_flag); // RL6
    end
  end

  // read state machine: take, fetch, answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
      rd_sel_q <= calib_pkg::SEL_NONE;
      rd_vec_q <= 1'b0;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (ar_take) begin
            rd_state <= RD_WAIT;
            rd_sel_q <= ar_sel;
            rd_vec_q <= vec_rd;
          end
        end
        RD_WAIT: rd_state <= RD_RESP;
        RD_RESP: begin
          if (rready) begin
            rd_state <= RD_IDLE;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  // read byte selection, reserved bits as zero
  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel_q)
      calib_pkg::SEL_GATE: rd_byte[calib_pkg::GATE_BIT] = gate;
      calib_pkg::SEL_VECTOR: rd_byte = rd_vec_q ? mem_bus.rdata : 8'h00; // RL1
      calib_pkg::SEL_GAIN_A: rd_byte = gain_adjust_first;
      calib_pkg::SEL_GAIN_B: rd_byte = gain_adjust_second;
      calib_pkg::SEL_REF: rd_byte[calib_pkg::REF_W-1:0] = reference_adjust_field; // RL10
      calib_pkg::SEL_TERM_A: rd_byte = termination_adjust_first;
      calib_pkg::SEL_CTRL: rd_byte[calib_pkg::FREEZE_BIT] = freeze;
      calib_pkg::SEL_STATUS: begin
        rd_byte[calib_pkg::ST_HALTED] = calibration_halted_flag;
        rd_byte[calib_pkg::ST_VALID] = calib_vector_valid;
        rd_byte[calib_pkg::ST_BUSY] = in_progress;
        rd_byte[calib_pkg::ST_HAZARD] = hazard;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // read data register, loaded in the fetch cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= 32'h0000_0000;
      rd_err_q <= 1'b0;
    end else if (rd_state == RD_WAIT) begin
      rdata <= {24'h00_0000, rd_byte};
      rd_err_q <= (rd_sel_q == calib_pkg::SEL_NONE);
    end
  end

  assign rresp = rd_err_q ? calib_pkg::RESP_SLVERR : calib_pkg::RESP_OKAY;

  // gate state for the analog side
  assign calib_access_enable = gate;

endmodule : calib_trim_regs

// [verif/calib_trim_regs_monitor.sv]
// port checker for the calibration and trim register block
`timescale 1ns/1ns
module calib_trim_regs_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [calib_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic [calib_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic [7:0] fuse_gain_first,
  input wire logic [7:0] fuse_gain_second,
  input wire logic [calib_pkg::REF_W-1:0] fuse_reference,
  input wire logic [7:0] fuse_termination_first,
  input wire logic [7:0] gain_adjust_first,
  input wire logic [7:0] gain_adjust_second,
  input wire logic [calib_pkg::REF_W-1:0] reference_adjust_field,
  input wire logic [7:0] termination_adjust_first,
  input wire logic calib_access_enable,
  input wire logic calib_vector_valid
);
  logic [calib_pkg::ADDR_W-1:0] aw_q;
  logic [calib_pkg::ADDR_W-1:0] ar_q;
  logic [7:0] w_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // last accepted write address, write byte and read address
  always_ff @(posedge aclk) begin
    if (awvalid && awready) aw_q <= awaddr;
    if (wvalid && wready) w_q <= wdata[7:0];
    if (arvalid && arready) ar_q <= araddr;
  end
  // trims leave reset at their fuse values
  a_fuse_gain: assert property (
    $rose(aresetn) |=> gain_adjust_first == $past(fuse_gain_first)
      && gain_adjust_second == $past(fuse_gain_second)) else $error("gain fuse load");
  a_fuse_other: assert property (
    $rose(aresetn) |=> reference_adjust_field == $past(fuse_reference)
      && termination_adjust_first == $past(fuse_termination_first)) else $error("fuse load");
  // a finished write lands in its register
  a_gain_write: assert property (
    $rose(bvalid) && bresp == 2'h0 |-> (aw_q != 12'h1E8 || gain_adjust_first == w_q)
      && (aw_q != 12'h1EC || gain_adjust_second == w_q)) else $error("gain write");
  a_ref_write: assert property (
    $rose(bvalid) && aw_q == 12'h1F0 |-> reference_adjust_field == w_q[3:0])
    else $error("reference write");
  a_gate_write: assert property (
    $rose(bvalid) && aw_q == 12'h1C0 |-> calib_access_enable == w_q[0]) else $error("gate write");
  // closed gate reads zero at the port; a trim reads back its value
  a_closed_port: assert property (
    $rose(rvalid) && ar_q == 12'h1C4 && !calib_access_enable |-> rdata == 32'h0)
    else $error("closed port read");
  a_read_trim: assert property (
    $rose(rvalid) && ar_q == 12'h1E8 |-> rdata == {24'h0, gain_adjust_first})
    else $error("trim readback");
  // vector becomes valid only on an open port access
  a_valid_source: assert property (
    $rose(calib_vector_valid) |-> calib_access_enable ##[0:2] (bvalid || rvalid))
    else $error("valid without access");
endmodule : calib_trim_regs_monitor

bind calib_trim_regs calib_trim_regs_monitor u_mon (.aclk, .aresetn, .awaddr, .awvalid, .awready,
  .wdata, .wvalid, .wready, .bresp, .bvalid, .araddr, .arvalid, .arready, .rdata, .rvalid,
  .fuse_gain_first, .fuse_gain_second, .fuse_reference, .fuse_termination_first,
  .gain_adjust_first, .gain_adjust_second, .reference_adjust_field, .termination_adjust_first,
  .calib_access_enable, .calib_vector_valid);

// [verif/tb_calib_trim_regs.sv]
// self-checking bench for the calibration and trim register block
`timescale 1ns/1ns
module tb_calib_trim_regs;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, halted;
  logic awready, wready, bvalid, arready, rvalid, en, vv;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, r1;
  logic [1:0] bresp, rresp;
  logic [7:0] g1, g2, t1;
  logic [7:0] fz [4];
  logic [7:0] tm [4] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF};
  logic [11:0] ta [4] = '{12'h1E8, 12'h1EC, 12'h1F0, 12'h1F8};
  logic [7:0] vec [673];
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  int num_errors = 0;
  int tests_run = 0;
  int seed = 94;
  calib_trim_regs u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .calibration_halted_flag(halted), .fuse_gain_first(fz[0]),
    .fuse_gain_second(fz[1]), .fuse_reference(fz[2][3:0]), .fuse_termination_first(fz[3]),
    .gain_adjust_first(g1), .gain_adjust_second(g2), .reference_adjust_field(r1),
    .termination_adjust_first(t1), .calib_access_enable(en), .calib_vector_valid(vv));
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  // one write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e = 2'h0);
    logic ha, hw, hb;
    bq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
  endtask : wr
  // one read; expected answer noted for the watcher
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    logic ha, hr;
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
  endtask : rd
  // compare each read answer and each write response with the oldest note of its kind
  always @(negedge aclk) begin
    if (aresetn && rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (aresetn && bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
  end
  task automatic flag(input logic e);
    @(negedge aclk);
    chk({33'h0, vv}, {33'h0, e});
  endtask : flag
  task automatic gate();
    wr(12'h1C0, 32'h0);
    wr(12'h1C0, 32'h1);
  endtask : gate
  // whole vector pass, first access at the port, the rest at a
  task automatic pass(input logic w, input logic [11:0] a);
    for (int i = 0; i < 673; i++) begin
      if (w) wr(i == 0 ? 12'h1C4 : a, {24'h0, vec[i]});
      else rd(i == 0 ? 12'h1C4 : a, {26'h0, vec[i]});
    end
  endtask : pass
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // cut a hung run short
  initial begin
    #400000;
    num_errors++;
    results();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, halted} = 7'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hF;
    for (int k = 0; k < 4; k++) fz[k] = 8'($random(seed));
    for (int i = 0; i < 673; i++) vec[i] = 8'($random(seed));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int k = 0; k < 4; k++) rd(ta[k], {26'h0, fz[k] & tm[k]});
    $display("test fuse values done");
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      wr(ta[k], d);
      rd(ta[k], {26'h0, d[7:0] & tm[k]});
    end
    rd(12'h100, {2'h2, 32'h0});
    wr(12'h100, 32'h0, 2'h2);
    $display("test trims done");
    rd(12'h1C0, 34'h0);
    wr(12'h1C4, 32'h5A);
    rd(12'h1C4, 34'h0);
    $display("test closed gate done");
    @(posedge aclk);
    halted <= 1'b1;
    gate();
    pass(1'b1, 12'h1C4);
    flag(1'b1);
    gate();
    repeat (10) wr(12'h1C4, 32'hFF);
    flag(1'b0);
    gate();
    wr(12'h200, 32'h1);
    pass(1'b1, 12'h100);
    gate();
    pass(1'b0, 12'h100);
    flag(1'b1);
    $display("test vector passes done");
    results();
  end
endmodule : tb_calib_trim_regs
